// [shared/cps_pkg.sv]
package cps_pkg;

  // ****************************************
  // frame layout
  // ****************************************
  localparam int unsigned FRAME_BITS       = 24;
  localparam int unsigned REG_COUNT        = 74;
  localparam logic [7:0]  ADDR_LAST        = 8'h49;
  localparam logic [7:0]  ADDR_FIRST       = 8'h00;
  localparam logic [1:0]  CHIP_ADDR_BITS   = 2'h0;
  localparam logic [4:0]  I2C_ADDR_UPPER   = 5'h04;
  localparam logic [4:0]  BIT_RW           = 5'd21;
  localparam logic [4:0]  BIT_ADDR_END     = 5'd16;
  localparam logic [4:0]  BIT_DATA_START   = 5'd16;
  localparam logic [7:0]  REG_RESET_VALUE  = 8'h00;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS    = 8;
  localparam int unsigned SCLK_MAX_KHZ     = 5000;
  localparam int unsigned SCLK_MIN_HALF_CYC =
    ((1000000 / SCLK_MAX_KHZ) / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [4:0] {
    I2C_IDLE = 5'b0_0001,
    I2C_RECV = 5'b0_0010,
    I2C_ACK  = 5'b0_0100,
    I2C_SEND = 5'b0_1000,
    I2C_RACK = 5'b1_0000
  } cps_i2c_state_t;

  typedef struct packed {
    logic select_low;
    logic clock;
    logic data_in;
  } cps_wire4_in_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } cps_i2c_in_t;

endpackage

// [rtl/cps_control_port_slave.sv]
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - 4-wire frame: chip address 00, direction bit, five unused bits, 8-bit address, 8-bit data, MSB first
// - 4-wire direction bit: 0 reads, 1 writes
// - 4-wire inputs sampled on rising clock, read data shifted on falling clock
// - 4-wire write commits data after the 24th rising clock edge
// - 4-wire data output released when select returns high
// - power-down pin low returns every register to default
// - strap low selects 4-wire, high selects I2C
// - I2C address 00100 plus two strap bits; last bit 1 means read
// - acknowledge a matching address byte and every later received byte: register address, data
// - I2C write: second byte register address, later bytes data
// - counter increments per data byte, wraps past 49H to 00H
// - I2C read: send eight bits, sample ack, continue or stop
// - current-address read uses counter left by last access
// - no acknowledge then STOP ends the read transfer
module cps_control_port_slave
  import cps_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // straps and power-down
  input  wire logic       power_down_pin_low_i,
  input  wire logic       bus_protocol_strap_i,
  input  wire logic       addr_strap_high_i,
  input  wire logic       addr_strap_low_i,
  // 4-wire port
  input  wire logic       serial_select_low_i,
  input  wire logic       serial_ctrl_clock_i,
  input  wire logic       serial_ctrl_in_i,
  output logic            serial_ctrl_out_o,
  output logic            serial_ctrl_out_oe_o,
  // i2c port
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  // register contents towards the device core
  output logic [REG_COUNT*8-1:0] reg_image_o
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [1:0]                  s_sel, s_clk, s_din, s_scl, s_sda, s_pdn, s_mode, s_cadh, s_cadl;
    cps_wire4_in_t               w4_prev;
    cps_i2c_in_t                 i2c_prev;
    logic [4:0]                  w4_count;
    logic [23:0]                 w4_shift;
    logic [7:0]                  w4_out;
    logic                        w4_drive;
    logic                        w4_dout;
    cps_i2c_state_t              st;
    logic [3:0]                  bit_count;
    logic [7:0]                  shift;
    logic [1:0]                  byte_idx;
    logic                        rd_mode;
    logic                        ack_low;
    logic [7:0]                  addr_ctr;
    logic [REG_COUNT*8-1:0]      regs;
  } cps_state_t;

  cps_state_t r, next_r;

  function automatic logic [7:0] next_addr(input logic [7:0] a);
    next_addr = (a >= ADDR_LAST) ? ADDR_FIRST : a + 8'h01;
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    cps_wire4_in_t w4;
    cps_i2c_in_t   ic;
    logic          w4_rise, w4_fall, scl_rise, scl_fall, start_c, stop_c, w4_act, i2c_act;
    logic [7:0]    a;
    a = 8'h00;
    next_r = r;
    // two flops on every pin before use
    next_r.s_sel  = {r.s_sel[0], serial_select_low_i};
    next_r.s_clk  = {r.s_clk[0], serial_ctrl_clock_i};
    next_r.s_din  = {r.s_din[0], serial_ctrl_in_i};
    next_r.s_scl  = {r.s_scl[0], scl_i};
    next_r.s_sda  = {r.s_sda[0], sda_i};
    next_r.s_pdn  = {r.s_pdn[0], power_down_pin_low_i};
    next_r.s_mode = {r.s_mode[0], bus_protocol_strap_i};
    next_r.s_cadh = {r.s_cadh[0], addr_strap_high_i};
    next_r.s_cadl = {r.s_cadl[0], addr_strap_low_i};
    w4 = '{select_low: r.s_sel[1], clock: r.s_clk[1], data_in: r.s_din[1]};
    ic = '{scl: r.s_scl[1], sda: r.s_sda[1]};
    next_r.w4_prev  = w4;
    next_r.i2c_prev = ic;
    w4_act   = !r.s_mode[1];
    i2c_act  = r.s_mode[1];
    w4_rise  = w4_act && !w4.select_low && w4.clock && !r.w4_prev.clock;
    w4_fall  = w4_act && !w4.select_low && !w4.clock && r.w4_prev.clock;
    scl_rise = i2c_act && ic.scl && !r.i2c_prev.scl;
    scl_fall = i2c_act && !ic.scl && r.i2c_prev.scl;
    start_c  = i2c_act && ic.scl && r.i2c_prev.scl && !ic.sda && r.i2c_prev.sda;
    stop_c   = i2c_act && ic.scl && r.i2c_prev.scl && ic.sda && !r.i2c_prev.sda;

    // ****************************************
    // 4-wire framing
    // ****************************************
    if (w4.select_low || !w4_act) begin
      next_r.w4_count = '0;
      next_r.w4_drive = 1'b0;
    end else if (w4_rise) begin
      next_r.w4_shift = {r.w4_shift[22:0], w4.data_in};
      if (r.w4_count < 5'(FRAME_BITS)) next_r.w4_count = r.w4_count + 5'd1;
      if (r.w4_count == 5'(FRAME_BITS - 1) && r.w4_shift[22:21] == CHIP_ADDR_BITS
          && r.w4_shift[20]) begin
        a = r.w4_shift[14:7];
        if (a <= ADDR_LAST) next_r.regs[a*8 +: 8] = {r.w4_shift[6:0], w4.data_in};
      end
      if (r.w4_count == BIT_DATA_START - 5'd1 && r.w4_shift[14:13] == CHIP_ADDR_BITS
          && !r.w4_shift[12]) begin
        a = {r.w4_shift[6:0], w4.data_in};
        next_r.w4_out = (a <= ADDR_LAST) ? r.regs[a*8 +: 8] : 8'h00;
        next_r.w4_drive = 1'b1;
      end
    end else if (w4_fall && r.w4_drive && r.w4_count >= BIT_DATA_START) begin
      next_r.w4_dout = r.w4_out[7];
      next_r.w4_out  = {r.w4_out[6:0], 1'b0};
    end

    // ****************************************
    // i2c slave
    // ****************************************
    if (!i2c_act || stop_c) begin
      next_r.st = I2C_IDLE;
      next_r.ack_low = 1'b0;
    end else if (start_c) begin
      next_r.st = I2C_RECV;
      next_r.bit_count = '0;
      next_r.byte_idx = '0;
      next_r.ack_low = 1'b0;
    end else begin
      case (r.st)
        I2C_RECV: begin
          if (scl_rise) begin
            next_r.shift = {r.shift[6:0], ic.sda};
            next_r.bit_count = r.bit_count + 4'd1;
          end else if (scl_fall && r.bit_count == 4'd8) begin
            next_r.bit_count = '0;
            if (r.byte_idx == 2'd0) begin
              if (r.shift[7:1] == {I2C_ADDR_UPPER, r.s_cadh[1], r.s_cadl[1]}) begin
                next_r.rd_mode = r.shift[0];
                next_r.ack_low = 1'b1;
                next_r.st = I2C_ACK;
              end else begin
                next_r.st = I2C_IDLE;
              end
            end else begin
              next_r.ack_low = 1'b1;
              next_r.st = I2C_ACK;
              if (r.byte_idx == 2'd1) begin
                next_r.addr_ctr = r.shift;
              end else begin
                if (r.addr_ctr <= ADDR_LAST) next_r.regs[r.addr_ctr*8 +: 8] = r.shift;
                next_r.addr_ctr = next_addr(r.addr_ctr);
              end
            end
            if (r.byte_idx != 2'd2) next_r.byte_idx = r.byte_idx + 2'd1;
          end
        end
        I2C_ACK: begin
          if (scl_fall) begin
            next_r.ack_low = 1'b0;
            if (r.rd_mode) begin
              next_r.st = I2C_SEND;
              next_r.shift = (r.addr_ctr <= ADDR_LAST) ? r.regs[r.addr_ctr*8 +: 8] : 8'h00;
              next_r.addr_ctr = next_addr(r.addr_ctr);
              next_r.bit_count = '0;
            end else begin
              next_r.st = I2C_RECV;
            end
          end
        end
        I2C_SEND: begin
          if (scl_fall) begin
            next_r.shift = {r.shift[6:0], 1'b1};
            next_r.bit_count = r.bit_count + 4'd1;
            if (r.bit_count == 4'd7) next_r.st = I2C_RACK;
          end
        end
        I2C_RACK: begin
          if (scl_rise) begin
            // high at ack clock means the master wants no more
            next_r.st = ic.sda ? I2C_IDLE : I2C_ACK;
          end
        end
        default: next_r.st = I2C_IDLE;
      endcase
    end

    // power-down wipes registers, taking priority over writes
    if (r.s_pdn[1] == 1'b0) begin
      next_r.regs = {REG_COUNT{REG_RESET_VALUE}};
      next_r.addr_ctr = ADDR_FIRST;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
      r.s_sel <= 2'b11;
      r.s_pdn <= 2'b11;
      // idle-high bus levels, so no false edge right after reset
      r.s_scl <= 2'b11;
      r.s_sda <= 2'b11;
      r.w4_prev <= '{select_low: 1'b1, clock: 1'b0, data_in: 1'b0};
      r.i2c_prev <= '{scl: 1'b1, sda: 1'b1};
      r.st <= I2C_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign serial_ctrl_out_o    = r.w4_dout;
  assign serial_ctrl_out_oe_o = r.w4_drive && !r.s_sel[1] && !r.s_mode[1];
  assign sda_o                = 1'b0;
  assign sda_oe_o             = r.ack_low || (r.st == I2C_SEND && !r.shift[7]);
  assign reg_image_o          = r.regs;

endmodule
`default_nettype wire

// [verif/cps_chk.sv]
`timescale 1ns/100ps
`default_nettype none
module cps_chk
  import cps_pkg::*;
(
  // watched ports
  input wire logic                   clk_i,
  input wire logic                   rst_i,
  input wire logic                   power_down_pin_low_i,
  input wire logic                   bus_protocol_strap_i,
  input wire logic                   serial_select_low_i,
  input wire logic                   serial_ctrl_clock_i,
  input wire logic                   scl_i,
  input wire logic                   serial_ctrl_out_o,
  input wire logic                   serial_ctrl_out_oe_o,
  input wire logic                   sda_o,
  input wire logic                   sda_oe_o,
  input wire logic [REG_COUNT*8-1:0] reg_image_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ******
  // quiet stretches
  // ******
  sequence s_sel_idle; serial_select_low_i [*6]; endsequence
  sequence s_w4_idle; (serial_select_low_i && power_down_pin_low_i && !bus_protocol_strap_i) [*8]; endsequence
  a_oe_release: assert property (s_sel_idle |-> !serial_ctrl_out_oe_o)
    else $error("out enable held");
  a_oe_strap: assert property (bus_protocol_strap_i [*6] |-> !serial_ctrl_out_oe_o)
    else $error("4-wire drives in i2c mode");
  a_sda_strap: assert property (!bus_protocol_strap_i [*6] |-> !sda_oe_o)
    else $error("sda driven in 4-wire mode");
  a_pd_clear: assert property (!power_down_pin_low_i [*5] |-> reg_image_o == '0)
    else $error("registers kept in power-down");
  a_img_hold: assert property (s_w4_idle |-> $stable(reg_image_o))
    else $error("register change outside frame");
  a_out_fall: assert property ((serial_ctrl_clock_i && !serial_select_low_i) [*8] |-> $stable(serial_ctrl_out_o))
    else $error("read data moved while clock high");
  a_sda_scl: assert property ((scl_i && bus_protocol_strap_i) [*4] |-> $stable(sda_oe_o))
    else $error("sda moved while scl high");
  a_sda_pull: assert property (sda_oe_o |-> !sda_o)
    else $error("sda driven high");
endmodule
bind cps_control_port_slave cps_chk chk (.clk_i, .rst_i, .power_down_pin_low_i, .bus_protocol_strap_i,
  .serial_select_low_i, .serial_ctrl_clock_i, .scl_i, .serial_ctrl_out_o, .serial_ctrl_out_oe_o, .sda_o,
  .sda_oe_o, .reg_image_o);
`default_nettype wire

// [verif/cps_host.sv]
`timescale 1ns/100ps
`default_nettype none
module cps_host (
  // 4-wire side
  input  wire logic sdo_i,
  output var logic  sel_o = 1'b1,
  output var logic  sclk_o = 1'b1,
  output var logic  sdi_o = 1'b0,
  // i2c side
  input  wire logic sda_i,
  output var logic  scl_o = 1'b1,
  output var logic  sda_low_o = 1'b0
);
  // ******
  // 4-wire frame, 104 ns halves keep it under 5 MHz
  // ******
  task automatic w4(input logic [1:0] chip, input logic rw, input logic [7:0] a, d, output logic [7:0] r);
    logic [23:0] f;
    f = {chip, rw, 5'h00, a, d};
    r = 8'h00;
    sel_o = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sclk_o = 1'b0;
      sdi_o = f[i];
      #104 sclk_o = 1'b1;
      if (i < 8) r = {r[6:0], sdo_i};
      #104;
    end
    sel_o = 1'b1;
    sdi_o = ~sdi_o;
    #104;
  endtask
  // ******
  // i2c bits, scl stands high between transfers
  // ******
  task automatic bit_o(input logic b);
    #8 sda_low_o = ~b;
    #32 scl_o = 1'b1;
    #40 scl_o = 1'b0;
  endtask
  task automatic bit_i(output logic b);
    #8 sda_low_o = 1'b0;
    #32 scl_o = 1'b1;
    #20 b = sda_i;
    #20 scl_o = 1'b0;
  endtask
  task automatic start();
    #8 sda_low_o = 1'b0;
    #32 scl_o = 1'b1;
    #40 sda_low_o = 1'b1;
    #40 scl_o = 1'b0;
  endtask
  task automatic stop();
    #8 sda_low_o = 1'b1;
    #32 scl_o = 1'b1;
    #40 sda_low_o = 1'b0;
    #40;
  endtask
  task automatic wb(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) bit_o(b[i]);
    bit_i(ack);
  endtask
  task automatic rb(input logic last, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) bit_i(b[i]);
    bit_o(last);
  endtask
endmodule
`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
`define CK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; $display("unexpected at %0t: %h %h", $time, g, e); end end
module testbench;
  import cps_pkg::*;
  logic       clk_i = 1'b0, rst_i = 1'b1, pd_low = 1'b1, strap = 1'b0, cad_h = 1'b0, cad_l = 1'b0, ack;
  logic [7:0] exp_reg [REG_COUNT];
  logic [7:0] a, d, r, p;
  int         err_total = 0, n_tests = 0, cyc = 0;
  wire logic  sdo, oe, sel, sclk, sdi, scl, sda_low, sda_oe, sda_w, sdo_bus;
  wire logic [REG_COUNT*8-1:0] img;
  assign sda_w = ~(sda_low | sda_oe);
  // released read line shows the inverse, so a late enable is caught
  assign sdo_bus = oe ? sdo : ~sdo;
  cps_control_port_slave dut (.clk_i, .rst_i, .power_down_pin_low_i(pd_low), .bus_protocol_strap_i(strap),
    .addr_strap_high_i(cad_h), .addr_strap_low_i(cad_l), .serial_select_low_i(sel), .serial_ctrl_clock_i(sclk),
    .serial_ctrl_in_i(sdi), .serial_ctrl_out_o(sdo), .serial_ctrl_out_oe_o(oe), .scl_i(scl), .sda_i(sda_w),
    .sda_o(), .sda_oe_o(sda_oe), .reg_image_o(img));
  cps_host host (.sdo_i(sdo_bus), .sel_o(sel), .sclk_o(sclk), .sdi_o(sdi), .sda_i(sda_w), .scl_o(scl),
    .sda_low_o(sda_low));
  // ******
  // helpers
  // ******
  function automatic logic [7:0] nxt(input logic [7:0] x);
    return (x >= ADDR_LAST) ? ADDR_FIRST : x + 8'h01;
  endfunction
  function automatic logic [REG_COUNT*8-1:0] exp_img();
    for (int i = 0; i < REG_COUNT; i++) exp_img[i*8+:8] = exp_reg[i];
  endfunction
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic i2c_wr(input logic [7:0] ra, input int n, input logic stp);
    host.start();
    host.wb({I2C_ADDR_UPPER, cad_h, cad_l, 1'b0}, ack);
    `CK(ack, 1'b0)
    host.wb(ra, ack);
    `CK(ack, 1'b0)
    a = ra;
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      host.wb(d, ack);
      `CK(ack, 1'b0)
      exp_reg[a] = d;
      a = nxt(a);
    end
    if (stp) host.stop();
  endtask
  task automatic i2c_rd(input int n);
    host.start();
    host.wb({I2C_ADDR_UPPER, cad_h, cad_l, 1'b1}, ack);
    `CK(ack, 1'b0)
    for (int i = 0; i < n; i++) begin
      host.rb(i == n - 1, r);
      `CK(r, exp_reg[a])
      a = nxt(a);
    end
    host.stop();
  endtask
  task automatic close_out();
    if (err_total == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial forever #4 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      close_out();
    end
  end
  // ******
  // main sequence
  // ******
  initial begin
    void'($urandom(7893));
    {cad_h, cad_l} = 2'($urandom);
    foreach (exp_reg[i]) exp_reg[i] = REG_RESET_VALUE;
    wt(20);
    rst_i = 1'b0;
    wt(4);
    `CK(img, exp_img())
    for (int i = 0; i < 8; i++) begin
      a = (i == 0) ? ADDR_LAST : 8'($urandom_range(73));
      d = 8'($urandom);
      host.w4(CHIP_ADDR_BITS, 1'b1, a, d, r);
      exp_reg[a] = d;
      wt(6);
      `CK(img, exp_img())
      host.w4(CHIP_ADDR_BITS, 1'b0, a, ~d, r);
      `CK(r, d)
    end
    host.w4(2'h1, 1'b1, a, ~d, r);
    wt(6);
    `CK(img, exp_img())
    pd_low = 1'b0;
    foreach (exp_reg[i]) exp_reg[i] = REG_RESET_VALUE;
    wt(6);
    `CK(img, exp_img())
    strap = 1'b1;
    wt(2);
    pd_low = 1'b1;
    wt(4);
    i2c_wr(8'h48, 3, 1'b1);
    wt(4);
    `CK(img, exp_img())
    i2c_wr(8'h48, 0, 1'b0);
    i2c_rd(3);
    p = 8'($urandom_range(73));
    i2c_wr(p, 1, 1'b1);
    i2c_wr(p, 0, 1'b0);
    i2c_rd(1);
    host.start();
    host.wb({I2C_ADDR_UPPER, ~cad_h, cad_l, 1'b0}, ack);
    `CK(ack, 1'b1)
    host.stop();
    i2c_rd(1);
    close_out();
  end
endmodule
`default_nettype wire
